// *** eri_pkg.sv ***
// eri_pkg: shared constants and types for the serial eeprom ram loader
// assumes one 25 MHz main clock and a 256x8 target ram write port
package eri_pkg;

  localparam int unsigned MCLK_HZ   = 25_000_000;
  localparam int unsigned BIT_DIV   = 2;
  localparam int unsigned BIT_HZ    = MCLK_HZ / BIT_DIV;

  localparam int unsigned BYTE_W    = 8;
  localparam int unsigned WORD_W    = 8;
  localparam int unsigned BIT_MSB   = 3;
  localparam int unsigned STEP_W    = 2;

  localparam logic [7:0] CMD_WRITE  = 8'hA0;
  localparam logic [7:0] CMD_READ   = 8'hA1;
  localparam logic [7:0] START_ADDR = 8'h00;

  localparam logic [1:0] STEP_A     = 2'h0;
  localparam logic [1:0] STEP_B     = 2'h1;
  localparam logic [1:0] STEP_C     = 2'h2;

  localparam logic       RST_HALF   = 1'b0;
  localparam logic       RST_SCK    = 1'b0;
  localparam logic       RST_SDO    = 1'b1;
  localparam logic       RST_INIT   = 1'b1;
  localparam logic       RST_STROBE = 1'b1;
  localparam logic       RST_NACK   = 1'b0;
  localparam logic [2:0] RST_SYNC   = 3'h7;

  typedef enum logic [3:0] {
    ST_INIT,
    ST_DEV_W,
    ST_ADDR,
    ST_RD_CMD,
    ST_READ,
    ST_STOP,
    ST_CMD_W,
    ST_WR_ADDR,
    ST_WR_DATA
  } eri_state_t;

  typedef enum logic [2:0] {
    OP_START,
    OP_BITS,
    OP_GAP1,
    OP_ACK,
    OP_GAP2,
    OP_STOP,
    OP_IDLE
  } eri_op_t;

endpackage : eri_pkg

// *** eri_pin_sync.sv ***
// eri_pin_sync: three-stage synchroniser for the serial data pin
// assumes the pin idles high (pulled up) and is asynchronous to mclk
`timescale 1ns/10ps
module eri_pin_sync (
  input  wire logic mclk,
  input  wire logic srst,
  input  wire logic pinIn,
  output logic      level
);
  import eri_pkg::*;

  logic [2:0] stage_q;
  logic [2:0] stage_d;
  logic       held_q;
  logic       held_d;

  // stage 0 feeds only stage 1; a change counts once stages 1 and 2 agree
  always_comb begin
    stage_d = {stage_q[1:0], pinIn};
    held_d  = (stage_q[1] == stage_q[2]) ? stage_q[2] : held_q;
    level   = held_d;
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      stage_q <= RST_SYNC;
      held_q  <= RST_SDO;
    end else begin
      stage_q <= stage_d;
      held_q  <= held_d;
    end
  end

endmodule : eri_pin_sync

// *** eri_master.sv ***
// eri_master: two-wire master that copies a serial eeprom into a ram,
// then writes single bytes back to the eeprom on request.
// assumes an external pull-up on the data wire and a ram clocked by
// ramWriteClock; update inputs come from logic on mclk.
// Functional notes
// - bit clock is main clock divided by two
// - serial clock follows, low in gaps, high during start/stop after their first step
// - ram clock is inverted bit clock
// - reset state: start, load write command
// - send command, address, restart, load read
// - read bytes, ack until last, flag nack
// - stop, wait request, start with write
// - send command; nack returns to stop
// - send address, then data, then stop
// - state counts up, back to stop after write data or a nack in a write state, zero on reset or on a nack in an early state
// - four-bit bit counter counts per bit
// - counter top bit marks eight bits, clears
// - word counter is the ram address
// - ram write enable low during read ack
// - master drives zero ack after read bytes but last
// - high ninth bit sets not-acknowledge flag
// - nack: early states restart, later stop
// - init flag high until stop state
// - write starts on request after init
// - update read strobe after address acked, as data loads
// - data output is open drain
`timescale 1ns/10ps
module eri_master #(
  parameter int ADDR_W = eri_pkg::WORD_W
) (
  input  wire logic                       mclk,
  input  wire logic                       srst,
  input  wire logic                       serialDataIn,
  output logic                            serialDataOut,
  output logic                            serialDataOutEn,
  output logic                            serialClock,
  output logic                            ramWriteClock,
  output logic                            ramWriteEnable_n,
  output logic [ADDR_W-1:0]               ramWriteAddress,
  output logic [eri_pkg::BYTE_W-1:0]      ramWriteData,
  input  wire logic                       updateRequest,
  input  wire logic [eri_pkg::BYTE_W-1:0] updateAddress,
  input  wire logic [eri_pkg::BYTE_W-1:0] updateData,
  output logic                            updateReadEnable_n,
  output logic                            initActive
);
  import eri_pkg::*;

  localparam logic [ADDR_W-1:0] LAST_WORD = '1;

  eri_state_t          state_q;
  eri_state_t          state_d;
  eri_op_t             op_q;
  eri_op_t             op_d;
  logic [STEP_W-1:0]   step_q;
  logic [STEP_W-1:0]   step_d;
  logic [BIT_MSB:0]    bitCnt_q;
  logic [BIT_MSB:0]    bitCnt_d;
  logic [BYTE_W-1:0]   tx_q;
  logic [BYTE_W-1:0]   tx_d;
  logic [BYTE_W-1:0]   rx_q;
  logic [BYTE_W-1:0]   rx_d;
  logic [BYTE_W-1:0]   ramData_q;
  logic [BYTE_W-1:0]   ramData_d;
  logic [ADDR_W-1:0]   word_q;
  logic [ADDR_W-1:0]   word_d;
  logic                half_q;
  logic                half_d;
  logic                sck_q;
  logic                sck_d;
  logic                ramClk_q;
  logic                ramClk_d;
  logic                sdo_q;
  logic                sdo_d;
  logic                sdoEn_q;
  logic                sdoEn_d;
  logic                ramWeN_q;
  logic                ramWeN_d;
  logic                updRdN_q;
  logic                updRdN_d;
  logic                init_q;
  logic                init_d;
  logic                nack_q;
  logic                nack_d;
  logic                rxFilt;
  logic                tick;
  logic                rxMode;
  logic                goStart;
  logic                goBits;
  logic                goStop;
  logic                nackSet;
  logic [BYTE_W-1:0]   loadByte;

  eri_pin_sync u_sdiSync (
    .mclk  (mclk),
    .srst  (srst),
    .pinIn (serialDataIn),
    .level (rxFilt)
  );

  // tick is the edge on which the bit clock falls; all data line changes happen here, while in bit and ack phases the serial clock rises on the other edge
  assign tick   = half_q;
  assign rxMode = (state_q == ST_READ);

  // the synchroniser lags by about three cycles, so a bit is captured on the
  // falling tick one bit later; gap phases hold the clock low to make room
  always_comb begin
    half_d    = ~half_q;
    state_d   = state_q;
    op_d      = op_q;
    step_d    = step_q;
    bitCnt_d  = bitCnt_q;
    tx_d      = tx_q;
    rx_d      = rx_q;
    ramData_d = ramData_q;
    word_d    = word_q;
    sdo_d     = sdo_q;
    ramWeN_d  = ramWeN_q;
    updRdN_d  = RST_STROBE;
    goStart   = 1'b0;
    goBits    = 1'b0;
    goStop    = 1'b0;
    nackSet   = 1'b0;
    loadByte  = tx_q;
    if (!tick) begin
      // enable spans exactly one rising ram clock edge, away from data changes
      ramWeN_d = !(op_q == OP_ACK && rxMode);
      if (!ramWeN_q && word_q != LAST_WORD) begin
        word_d = word_q + 1'b1;
      end
    end else begin
      unique case (op_q)
        OP_START: begin
          unique case (step_q)
            STEP_A: step_d = STEP_B;
            STEP_B: begin
              sdo_d  = 1'b0;
              step_d = STEP_C;
            end
            default: begin
              goBits = 1'b1;
              if (state_q == ST_INIT) begin
                state_d = ST_DEV_W;
              end
            end
          endcase
        end
        OP_BITS: begin
          bitCnt_d = bitCnt_q + 4'h1;
          if (bitCnt_q != '0) begin
            rx_d = {rx_q[BYTE_W-2:0], rxFilt};
          end
          if (bitCnt_d[BIT_MSB]) begin
            bitCnt_d = '0;
            op_d     = OP_GAP1;
          end else if (!rxMode) begin
            sdo_d = tx_q[BYTE_W-1];
            tx_d  = {tx_q[BYTE_W-2:0], 1'b0};
          end
        end
        OP_GAP1: begin
          ramData_d = {rx_q[BYTE_W-2:0], rxFilt};
          op_d      = OP_ACK;
          if (rxMode) begin
            sdo_d   = (word_q == LAST_WORD);
            nackSet = (word_q == LAST_WORD);
          end else begin
            sdo_d = 1'b1;
          end
        end
        OP_ACK: begin
          if (!rxMode) begin
            op_d = OP_GAP2;
          end else if (nack_q) begin
            goStop = 1'b1;
          end else begin
            goBits = 1'b1;
          end
        end
        OP_GAP2: begin
          if (rxFilt) begin
            nackSet = 1'b1;
            if (state_q <= ST_RD_CMD) begin
              state_d  = ST_INIT;
              loadByte = CMD_WRITE;
              goStart  = 1'b1;
            end else begin
              goStop = 1'b1;
            end
          end else begin
            unique case (state_q)
              ST_DEV_W: begin
                state_d  = ST_ADDR;
                loadByte = START_ADDR;
                goBits   = 1'b1;
              end
              ST_ADDR: begin
                state_d  = ST_RD_CMD;
                loadByte = CMD_READ;
                goStart  = 1'b1;
              end
              ST_RD_CMD: begin
                state_d = ST_READ;
                word_d  = '0;
                goBits  = 1'b1;
              end
              ST_CMD_W: begin
                state_d  = ST_WR_ADDR;
                loadByte = updateAddress;
                goBits   = 1'b1;
              end
              ST_WR_ADDR: begin
                state_d  = ST_WR_DATA;
                loadByte = updateData;
                updRdN_d = 1'b0;
                goBits   = 1'b1;
              end
              // data byte sent; other codes cannot reach a gap
              default: goStop = 1'b1;
            endcase
          end
        end
        OP_STOP: begin
          if (step_q == STEP_A) begin
            step_d = STEP_B;
          end else begin
            sdo_d = 1'b1;
            op_d  = OP_IDLE;
          end
        end
        OP_IDLE: begin
          if (updateRequest && !init_q) begin
            state_d  = ST_CMD_W;
            loadByte = CMD_WRITE;
            goStart  = 1'b1;
          end
        end
        default: goStop = 1'b1;
      endcase
      if (goStart) begin
        op_d   = OP_START;
        step_d = STEP_A;
        sdo_d  = 1'b1;
        tx_d   = loadByte;
      end
      if (goBits) begin
        op_d     = OP_BITS;
        bitCnt_d = '0;
        if (state_d == ST_READ) begin
          sdo_d = 1'b1;
        end else begin
          sdo_d = loadByte[BYTE_W-1];
          tx_d  = {loadByte[BYTE_W-2:0], 1'b0};
        end
      end
      if (goStop) begin
        op_d    = OP_STOP;
        step_d  = STEP_A;
        sdo_d   = 1'b0;
        state_d = ST_STOP;
      end
    end
    // a fresh start clears the flag, but a nack in the same tick still wins
    nack_d = goStart ? nackSet : (nack_q | nackSet);
    unique case (op_d)
      OP_BITS, OP_ACK:  sck_d = half_d;
      OP_GAP1, OP_GAP2: sck_d = 1'b0;
      OP_START, OP_STOP: sck_d = (step_d != STEP_A);
      default:          sck_d = 1'b1;
    endcase
    ramClk_d = ~half_d;
    sdoEn_d  = ~sdo_d;
    init_d   = init_q & (state_d != ST_STOP);
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      state_q   <= ST_INIT;
      op_q      <= OP_START;
      step_q    <= STEP_A;
      bitCnt_q  <= '0;
      tx_q      <= CMD_WRITE;
      rx_q      <= '0;
      ramData_q <= '0;
      word_q    <= '0;
      half_q    <= RST_HALF;
      sck_q     <= RST_SCK;
      ramClk_q  <= ~RST_HALF;
      sdo_q     <= RST_SDO;
      sdoEn_q   <= ~RST_SDO;
      ramWeN_q  <= RST_STROBE;
      updRdN_q  <= RST_STROBE;
      init_q    <= RST_INIT;
      nack_q    <= RST_NACK;
    end else begin
      state_q   <= state_d;
      op_q      <= op_d;
      step_q    <= step_d;
      bitCnt_q  <= bitCnt_d;
      tx_q      <= tx_d;
      rx_q      <= rx_d;
      ramData_q <= ramData_d;
      word_q    <= word_d;
      half_q    <= half_d;
      sck_q     <= sck_d;
      ramClk_q  <= ramClk_d;
      sdo_q     <= sdo_d;
      sdoEn_q   <= sdoEn_d;
      ramWeN_q  <= ramWeN_d;
      updRdN_q  <= updRdN_d;
      init_q    <= init_d;
      nack_q    <= nack_d;
    end
  end

  assign serialDataOut      = sdo_q;
  assign serialDataOutEn    = sdoEn_q;
  assign serialClock        = sck_q;
  assign ramWriteClock      = ramClk_q;
  assign ramWriteEnable_n   = ramWeN_q;
  assign ramWriteAddress    = word_q;
  assign ramWriteData       = ramData_q;
  assign updateReadEnable_n = updRdN_q;
  assign initActive         = init_q;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  sequence startCond;
    (!sck_q && sdo_q) [*2] ##1 (sck_q && sdo_q) [*2] ##1 (sck_q && !sdo_q) [*2];
  endsequence

  sequence stopCond;
    (!sck_q && !sdo_q) [*2] ##1 (sck_q && !sdo_q) [*2];
  endsequence

  sequence ramPulse;
    !ramWeN_q ##1 !ramWeN_q ##1 ramWeN_q;
  endsequence

  // first edge after release still sees the held reset value
  a_bit_divide: assert property (!$past(srst) |-> half_q != $past(half_q))
    else $error("bit clock did not toggle");

  a_ram_clock_inv: assert property (ramClk_q == ~half_q)
    else $error("ram clock is not the inverted bit clock");

  a_sck_follow: assert property ((op_q == OP_BITS || op_q == OP_ACK) |-> sck_q == half_q)
    else $error("serial clock not following bit clock");

  a_start_shape: assert property ($rose(op_q == OP_START) |-> startCond ##1 (op_q == OP_BITS && !sck_q))
    else $error("start condition malformed");

  a_stop_shape: assert property ($rose(op_q == OP_STOP) |-> stopCond ##1 (sck_q && sdo_q && op_q == OP_IDLE))
    else $error("stop condition malformed");

  a_init_cmd: assert property (state_q == ST_INIT |-> tx_q == CMD_WRITE)
    else $error("write command not loaded in reset state");

  a_eight_bits: assert property ($rose(op_q == OP_GAP1) |-> $past(bitCnt_q) == 4'h7)
    else $error("byte did not span eight bits");

  a_ram_pulse: assert property ($fell(ramWeN_q) |-> rxMode && op_q == OP_ACK ##0 ramPulse)
    else $error("ram write pulse wrong");

  a_word_step: assert property ($rose(ramWeN_q) && $past(word_q) != LAST_WORD |-> word_q == $past(word_q) + 1'b1)
    else $error("word counter did not advance");

  a_read_ack: assert property (op_q == OP_ACK && rxMode && word_q != LAST_WORD |-> !sdo_q && sdoEn_q)
    else $error("read byte not acknowledged");

  a_nack_route: assert property ($past(tick && op_q == OP_GAP2 && rxFilt) |-> state_q == ST_INIT || state_q == ST_STOP)
    else $error("nack did not redirect the controller");

  a_init_drop: assert property ($fell(init_q) |-> state_q == ST_STOP ##1 !init_q)
    else $error("init flag dropped outside stop");

  a_write_gate: assert property ($rose(state_q == ST_CMD_W) |-> $past(updateRequest) && !$past(init_q))
    else $error("eeprom write began without request");

  a_upd_strobe: assert property ($fell(updRdN_q) |-> state_q == ST_WR_DATA && $past(state_q) == ST_WR_ADDR ##1 updRdN_q)
    else $error("update read strobe misplaced");

endmodule : eri_master

// *** eri_eeprom_model.sv ***
// eri_eeprom_model: behavioural serial eeprom on the far side of the link
// assumes the bench resolves the data wire with a pull-up; looks at the link on falling mclk
`timescale 1ns/10ps
module eri_eeprom_model (
  input  wire logic mclk,
  input  wire logic scl,
  input  wire logic sda,
  input  wire logic refuseSel,
  output logic      sdaLow
);
  logic [7:0] mem [256];
  logic [7:0] rxLog [$];
  logic [7:0] sr;
  logic [7:0] addr;
  logic       sclP;
  logic       sdaP;
  logic       rd;
  logic       rdNext;
  logic       mAck;
  int         cnt;
  int         phase;
  int         nStops;

  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i) ^ 8'h5A;
    end
    {sr, addr, sclP, sdaP, rd, rdNext, mAck, sdaLow} = '0;
    cnt = 0;
    phase = 0;
    nStops = 0;
  end

  // sampling between mclk edges keeps clock and data changes of one edge together
  always @(negedge mclk) begin
    if (sclP && scl && sdaP && !sda) begin
      cnt = 0;
      phase = 0;
      rd = 1'b0;
      rdNext = 1'b0;
      sdaLow = 1'b0;
    end else if (sclP && scl && !sdaP && sda) begin
      nStops++;
      cnt = 0;
      rd = 1'b0;
      sdaLow = 1'b0;
    end else if (!sclP && scl) begin
      cnt++;
      if (!rd && cnt <= 8) begin
        sr = {sr[6:0], sda};
      end
      if (rd && cnt == 9) begin
        mAck = sda;
      end
    end else if (sclP && !scl) begin
      if (!rd && cnt == 8) begin
        rxLog.push_back(sr);
        sdaLow = 1'b1;
        case (phase)
          0: begin
            sdaLow = (sr[7:1] == 7'h50) && !refuseSel;
            rdNext = sr[0];
          end
          1: addr = sr;
          default: begin
            mem[addr] = sr;
            addr++;
          end
        endcase
        if (sdaLow) begin
          phase++;
        end
      end else if (cnt == 9) begin
        cnt = 0;
        sdaLow = 1'b0;
        if (rdNext) begin
          rd = 1'b1;
          rdNext = 1'b0;
        end else if (rd && mAck) begin
          rd = 1'b0;
        end
      end
      // next read byte only goes out after the master acked the last one
      if (rd && cnt < 8) begin
        sdaLow = !mem[addr][7 - cnt];
      end
      if (rd && cnt == 8) begin
        sdaLow = 1'b0;
        addr++;
      end
    end
    sclP = scl;
    sdaP = sda;
  end
endmodule : eri_eeprom_model

// *** tb_eri_master.sv ***
// tb_eri_master: self-checking bench for the eeprom ram loader
// assumes eri_eeprom_model on the data wire with a pull-up resolved here
`timescale 1ns/10ps
module tb_eri_master;
  import eri_pkg::*;
  logic       mclk;
  logic       srst;
  logic       sdaWire;
  logic       eeLow;
  logic       refuseSel;
  logic       updateRequest;
  logic [7:0] updateAddress;
  logic [7:0] updateData;
  logic       serialDataOut;
  logic       serialDataOutEn;
  logic       serialClock;
  logic       ramWriteClock;
  logic       ramWriteEnable_n;
  logic [7:0] ramWriteAddress;
  logic [7:0] ramWriteData;
  logic       updateReadEnable_n;
  logic       initActive;
  logic [7:0] ramImg [256];
  logic [7:0] expLog [10] = '{8'hA0, 8'hA0, 8'h00, 8'hA1, 8'hA0, 8'h3C, 8'hC3, 8'hA0, 8'hFF, 8'h00};
  int         n_fail;
  int         comparisons;
  int         nWrites;
  int         nStrobes;
  int         n;

  assign sdaWire = (serialDataOutEn || eeLow) ? 1'b0 : 1'b1;

  eri_master u_dut (
    .mclk               (mclk),
    .srst               (srst),
    .serialDataIn       (sdaWire),
    .serialDataOut      (serialDataOut),
    .serialDataOutEn    (serialDataOutEn),
    .serialClock        (serialClock),
    .ramWriteClock      (ramWriteClock),
    .ramWriteEnable_n   (ramWriteEnable_n),
    .ramWriteAddress    (ramWriteAddress),
    .ramWriteData       (ramWriteData),
    .updateRequest      (updateRequest),
    .updateAddress      (updateAddress),
    .updateData         (updateData),
    .updateReadEnable_n (updateReadEnable_n),
    .initActive         (initActive)
  );

  eri_eeprom_model u_ee (
    .mclk      (mclk),
    .scl       (serialClock),
    .sda       (sdaWire),
    .refuseSel (refuseSel),
    .sdaLow    (eeLow)
  );

  always #20 mclk = ~mclk;

  always @(posedge ramWriteClock) begin
    if (ramWriteEnable_n === 1'b0) begin
      ramImg[ramWriteAddress] = ramWriteData;
      nWrites++;
    end
  end

  always @(negedge mclk) begin
    if (updateReadEnable_n === 1'b0) begin
      nStrobes++;
    end
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run

  // one byte write request; keep holds the request for a following byte
  task automatic eeWrite(input logic [7:0] a, input logic [7:0] d, input logic keep);
    int k;
    @(negedge mclk);
    updateAddress = a;
    updateData = d;
    updateRequest = 1'b1;
    k = 0;
    while (updateReadEnable_n !== 1'b0 && k < 400) begin
      @(negedge mclk);
      k++;
    end
    check("update strobe", 16'(k < 400), 16'h0001);
    updateRequest = keep;
  endtask : eeWrite

  task automatic waitStop;
    int s;
    int k;
    s = u_ee.nStops;
    k = 0;
    while (u_ee.nStops == s && k < 400) begin
      @(negedge mclk);
      k++;
    end
  endtask : waitStop

  initial begin
    mclk = 1'b0;
    srst = 1'b1;
    refuseSel = 1'b1;
    updateRequest = 1'b0;
    updateAddress = 8'h00;
    updateData = 8'h00;
    {n_fail, comparisons, nWrites, nStrobes} = '0;
    repeat (4) @(negedge mclk);
    check("initActive reset", 16'(initActive), 16'h0001);
    check("ram enable reset", 16'(ramWriteEnable_n), 16'h0001);
    check("update strobe reset", 16'(updateReadEnable_n), 16'h0001);
    check("data enable reset", 16'(serialDataOutEn), 16'h0000);
    check("data out reset", 16'(serialDataOut), 16'h0001);
    srst = 1'b0;
    n = 0;
    // first device select is refused: the read must restart from the top
    while (u_ee.rxLog.size() < 1 && n < 200) begin
      @(negedge mclk);
      n++;
    end
    refuseSel = 1'b0;
    n = 0;
    while (initActive !== 1'b0 && n < 20000) begin
      @(negedge mclk);
      n++;
    end
    check("init done", 16'(n < 20000), 16'h0001);
    check("ram writes", 16'(nWrites), 16'h0100);
    for (int i = 0; i < 256; i++) begin
      check("ram word", 16'(ramImg[i]), 16'(8'(i) ^ 8'h5A));
    end
    check("last byte unacked", 16'(u_ee.mAck), 16'h0001);
    eeWrite(8'h3C, 8'hC3, 1'b1);
    eeWrite(8'hFF, 8'h00, 1'b0);
    waitStop();
    check("log size", 16'(u_ee.rxLog.size()), 16'h000A);
    for (int i = 0; i < 10; i++) begin
      check("link byte", 16'(u_ee.rxLog[i]), 16'(expLog[i]));
    end
    check("eeprom 3C", 16'(u_ee.mem[8'h3C]), 16'h00C3);
    check("eeprom FF", 16'(u_ee.mem[8'hFF]), 16'h0000);
    check("strobes", 16'(nStrobes), 16'h0002);
    refuseSel = 1'b1;
    updateAddress = 8'h11;
    updateData = 8'h22;
    n = u_ee.rxLog.size();
    updateRequest = 1'b1;
    // drop the request once the refused command byte is seen, so one attempt only
    while (u_ee.rxLog.size() == n) begin
      @(negedge mclk);
    end
    updateRequest = 1'b0;
    waitStop();
    check("refused command", 16'(u_ee.rxLog[n]), 16'h00A0);
    refuseSel = 1'b0;
    check("no strobe on refusal", 16'(nStrobes), 16'h0002);
    check("eeprom 11 kept", 16'(u_ee.mem[8'h11]), 16'h004B);
    eeWrite(8'h11, 8'h22, 1'b0);
    waitStop();
    check("eeprom 11", 16'(u_ee.mem[8'h11]), 16'h0022);
    check("initActive low", 16'(initActive), 16'h0000);
    check("ram writes after", 16'(nWrites), 16'h0100);
    complete_run();
  end

  initial begin
    #1_600_000;
    n_fail++;
    $display("CHECK FAILED watchdog expected done seen hang");
    complete_run();
  end
endmodule : tb_eri_master
